// ==== src/scs_ctrl.v ====
// Summary of operation
// - SPI tx-idle flag: transmit FIFO empty and shifter idle.
// - SPI tx-space flag: transmit FIFO can take a byte.
// - SPI rx-valid flag: receive FIFO holds a byte.
// - SPI overrun flag sets when a byte arrives into a full receive FIFO.
// - Reading the data register clears the overrun flag.
// - Stop command bit sends STOP, self-clears when done.
// - Start command bit sends START or repeated START, self-clears.
// - Send bit transmits a byte, receive bit receives one; both self-clear.
// - After a received byte drive ACK if ack select is one, else NACK.
// - Command-finished flag sets when START or STOP completes.
// - Receive-finished flag sets when a byte is received.
// - Transmit-finished flag sets when a byte is sent.
// - NACK-received flag sets when slave NACKs a sent byte.
// - All I2C status flags clear when the next bus operation begins.
// - Data write pushes low byte to transmit FIFO; read pops receive FIFO.
// - Mode 0/1 disabled, 2 SPI, 3 I2C; disable before switching.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "scs_defs.vh"

module scs_ctrl #(
	parameter [15:0] QTR_TICKS = `SCS_QTR_DEF,
	parameter        FIFO_AW   = 2
) (
	input  wire        i_clk_sys,
	input  wire        i_rstn,
	input  wire [19:0] i_awaddr,
	input  wire        i_awvalid,
	output reg         o_awready,
	input  wire [31:0] i_wdata,
	input  wire [3:0]  i_wstrb,
	input  wire        i_wvalid,
	output reg         o_wready,
	output reg  [1:0]  o_bresp,
	output reg         o_bvalid,
	input  wire        i_bready,
	input  wire [19:0] i_araddr,
	input  wire        i_arvalid,
	output reg         o_arready,
	output reg  [31:0] o_rdata,
	output reg  [1:0]  o_rresp,
	output reg         o_rvalid,
	input  wire        i_rready,
	input  wire        i_scl_in,
	output reg         o_scl_out,
	output reg         o_scl_oe,
	input  wire        i_sda_in,
	output reg         o_sda_out,
	output reg         o_sda_oe,
	output reg         o_irq
);
	localparam ST_IDLE = 3'h0, ST_START = 3'h1, ST_STOP = 3'h2, ST_BIT = 3'h3;

	reg  [1:0]  scl_s, sda_s;
	reg  [1:0]  mode;
	reg  [3:0]  cmd;
	reg         ack_sel;
	reg  [3:0]  i2c_st;
	reg         rx_ovr;
	reg  [3:0]  dma_load;
	reg  [7:0]  dma_cnt [0:3];
	reg  [3:0]  irq_st, irq_mask;
	reg  [2:0]  state;
	reg  [1:0]  phase;
	reg  [3:0]  bit_n;
	reg  [8:0]  shreg;
	reg  [15:0] tick;
	reg         owned;
	reg         aw_h, w_h;
	reg  [19:0] aw_a;
	reg  [31:0] w_d;
	reg  [3:0]  w_s;
	reg         tx_pop, rx_push;
	reg  [7:0]  rx_byte;
	wire [7:0]  tx_byte;
	wire [7:0]  rx_q;
	wire        tx_empty, tx_full, rx_empty, rx_full;
	wire        scl_pin = scl_s[1];
	wire        sda_pin = sda_s[1];
	wire        i2c_on  = (mode == `SCS_MODE_I2C);
	wire        qtick   = (tick == 16'h0000);

	// Bus decode
	wire        wr_go  = aw_h && w_h && !o_bvalid;
	wire [17:0] wr_idx = aw_a[19:2];
	wire        rd_go  = i_arvalid && o_arready;
	wire [17:0] rd_idx = i_araddr[19:2];
	wire        wr_data = wr_go && w_s[0] && (wr_idx == `SCS_IDX_DATA);
	wire        rd_data = rd_go && (rd_idx == `SCS_IDX_DATA);
	wire        wr_cmd  = wr_go && w_s[0] && (wr_idx == `SCS_IDX_I2C_CMD);
	wire        wr_dma  = wr_go && w_s[0] && (wr_idx == `SCS_IDX_DMA_CTRL);
	wire        rd_irq  = rd_go && (rd_idx == `SCS_IDX_IRQ_STAT);

	wire        op_begin = (state == ST_IDLE) && i2c_on && (cmd != 4'h0) && qtick;
	wire        spi_idle = tx_empty && (state == ST_IDLE);
	wire [3:0]  spi_st   = {spi_idle, !tx_full, !rx_empty, rx_ovr};
	reg  [3:0]  fin_set;
	wire [3:0]  dma_done;

	scs_fifo #(.W(8), .AW(FIFO_AW)) u_txf (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_clr     (!i2c_on),
		.i_push    (wr_data),
		.i_wdata   (w_d[7:0]),
		.i_pop     (tx_pop),
		.o_rdata   (tx_byte),
		.o_empty   (tx_empty),
		.o_full    (tx_full)
	);

	scs_fifo #(.W(8), .AW(FIFO_AW)) u_rxf (
		.i_clk_sys (i_clk_sys),
		.i_rstn    (i_rstn),
		.i_clr     (!i2c_on),
		.i_push    (rx_push),
		.i_wdata   (rx_byte),
		.i_pop     (rd_data),
		.o_rdata   (rx_q),
		.o_empty   (rx_empty),
		.o_full    (rx_full)
	);

	// Pin synchronisers
	always @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			scl_s <= 2'h3;
			sda_s <= 2'h3;
		end
		else
		begin
			scl_s <= {scl_s[0], i_scl_in};
			sda_s <= {sda_s[0], i_sda_in};
		end
	end

	// AXI write channel
	always @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			aw_h      <= 1'b0;
			w_h       <= 1'b0;
			aw_a      <= 20'h00000;
			w_d       <= 32'h00000000;
			w_s       <= 4'h0;
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_bvalid  <= 1'b0;
			o_bresp   <= 2'h0;
		end
		else
		begin
			o_awready <= !aw_h && !(i_awvalid && o_awready) && !o_bvalid;
			o_wready  <= !w_h && !(i_wvalid && o_wready) && !o_bvalid;
			if (i_awvalid && o_awready)
			begin
				aw_h <= 1'b1;
				aw_a <= i_awaddr;
			end
			if (i_wvalid && o_wready)
			begin
				w_h <= 1'b1;
				w_d <= i_wdata;
				w_s <= i_wstrb;
			end
			if (wr_go)
			begin
				aw_h     <= 1'b0;
				w_h      <= 1'b0;
				o_bvalid <= 1'b1;
				case (wr_idx)
					`SCS_IDX_DATA, `SCS_IDX_I2C_CMD, `SCS_IDX_I2C_ACK, `SCS_IDX_DMA_CTRL,
					`SCS_IDX_MODE, `SCS_IDX_IRQ_MASK, `SCS_IDX_SPI_STAT, `SCS_IDX_I2C_STAT,
					`SCS_IDX_IRQ_STAT: o_bresp <= 2'h0;
					default:           o_bresp <= 2'h2;
				endcase
			end
			else if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
		end
	end

	// AXI read channel
	always @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_arready <= 1'b0;
			o_rvalid  <= 1'b0;
			o_rdata   <= 32'h00000000;
			o_rresp   <= 2'h0;
		end
		else
		begin
			o_arready <= !o_rvalid && !(i_arvalid && o_arready);
			if (rd_go)
			begin
				o_rvalid <= 1'b1;
				o_rresp  <= 2'h0;
				case (rd_idx)
					`SCS_IDX_DATA:     o_rdata <= {24'h000000, rx_empty ? 8'h00 : rx_q};
					`SCS_IDX_SPI_STAT: o_rdata <= {28'h0000000, spi_st};
					`SCS_IDX_I2C_STAT: o_rdata <= {28'h0000000, i2c_st};
					`SCS_IDX_I2C_CMD:  o_rdata <= {28'h0000000, cmd};
					`SCS_IDX_I2C_ACK:  o_rdata <= {31'h00000000, ack_sel};
					`SCS_IDX_DMA_CTRL: o_rdata <= {28'h0000000, dma_load};
					`SCS_IDX_MODE:     o_rdata <= {30'h00000000, mode};
					`SCS_IDX_IRQ_STAT: o_rdata <= {28'h0000000, irq_st};
					`SCS_IDX_IRQ_MASK: o_rdata <= {28'h0000000, irq_mask};
					default:
					begin
						o_rdata <= 32'h00000000;
						o_rresp <= 2'h2;
					end
				endcase
			end
			else if (o_rvalid && i_rready)
				o_rvalid <= 1'b0;
		end
	end

	// Software registers and flags
	always @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			mode     <= `SCS_RST_MODE;
			ack_sel  <= `SCS_RST_ACK;
			rx_ovr   <= 1'b0;
			irq_mask <= 4'h0;
			irq_st   <= 4'h0;
			dma_load <= 4'h0;
			o_irq    <= 1'b0;
		end
		else
		begin
			if (wr_go && w_s[0] && wr_idx == `SCS_IDX_MODE)
				mode <= w_d[1:0];
			if (wr_go && w_s[0] && wr_idx == `SCS_IDX_I2C_ACK)
				ack_sel <= w_d[0];
			if (wr_go && w_s[0] && wr_idx == `SCS_IDX_IRQ_MASK)
				irq_mask <= w_d[3:0];
			if (rx_push && rx_full)
				rx_ovr <= 1'b1;
			else if (rd_data)
				rx_ovr <= 1'b0;
			irq_st <= (rd_irq ? 4'h0 : irq_st) | fin_set;
			o_irq  <= |(irq_st & irq_mask);
			if (wr_dma && w_d[`SCS_DMA_TXRST])
				dma_load[3:2] <= 2'h0;
			if (wr_dma && w_d[`SCS_DMA_RXRST])
				dma_load[1:0] <= 2'h0;
			if (wr_dma)
				dma_load <= (dma_load | w_d[3:0]) &
					~{{2{w_d[`SCS_DMA_TXRST]}}, {2{w_d[`SCS_DMA_RXRST]}}};
			else
				dma_load <= dma_load & ~dma_done;
		end
	end

	// Buffer service timers: each marked buffer completes after a fixed time
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1)
		begin : g_dma
			assign dma_done[g] = dma_load[g] && (dma_cnt[g] == `SCS_DMA_DONE_CYC);
			always @(posedge i_clk_sys or negedge i_rstn)
			begin
				if (!i_rstn)
					dma_cnt[g] <= 8'h00;
				else if (!dma_load[g] || dma_done[g])
					dma_cnt[g] <= 8'h00;
				else
					dma_cnt[g] <= dma_cnt[g] + 8'h01;
			end
		end
	endgenerate

	// I2C master engine
	always @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			state     <= ST_IDLE;
			phase     <= 2'h0;
			bit_n     <= 4'h0;
			shreg     <= 9'h000;
			tick      <= 16'h0000;
			owned     <= 1'b0;
			cmd       <= 4'h0;
			i2c_st    <= 4'h0;
			fin_set   <= 4'h0;
			tx_pop    <= 1'b0;
			rx_push   <= 1'b0;
			rx_byte   <= 8'h00;
			o_scl_out <= 1'b0;
			o_scl_oe  <= 1'b0;
			o_sda_out <= 1'b0;
			o_sda_oe  <= 1'b0;
		end
		else
		begin
			tx_pop  <= 1'b0;
			rx_push <= 1'b0;
			fin_set <= 4'h0;
			tick    <= qtick ? QTR_TICKS : tick - 16'h0001;
			if (wr_cmd && state == ST_IDLE)
				cmd <= cmd | w_d[3:0];
			if (!i2c_on)
			begin
				state <= ST_IDLE;
				owned <= 1'b0;
				cmd   <= 4'h0;
				o_scl_oe <= 1'b0;
				o_sda_oe <= 1'b0;
			end
			else if (op_begin)
			begin
				i2c_st <= 4'h0;
				phase  <= 2'h0;
				if (cmd[`SCS_CMD_STOP])
					state <= ST_STOP;
				else if (cmd[`SCS_CMD_START])
					state <= ST_START;
				else
				begin
					state <= ST_BIT;
					bit_n <= 4'h0;
					shreg <= cmd[`SCS_CMD_SEND] ? {tx_byte, 1'b1} : {8'hff, !ack_sel};
					tx_pop <= cmd[`SCS_CMD_SEND];
				end
			end
			else if (qtick && state != ST_IDLE)
			begin
				phase <= phase + 2'h1;
				case (state)
					ST_START:
					begin
						// High SDA and SCL, then SDA falls with SCL high
						o_scl_oe <= (phase == 2'h3);
						o_sda_oe <= (phase >= 2'h2);
						if (phase == 2'h3)
						begin
							state <= ST_IDLE;
							owned <= 1'b1;
							cmd[`SCS_CMD_START] <= 1'b0;
							i2c_st[`SCS_ST_CMDFIN] <= 1'b1;
							fin_set[`SCS_ST_CMDFIN] <= 1'b1;
						end
					end
					ST_STOP:
					begin
						o_sda_oe <= (phase <= 2'h1);
						o_scl_oe <= (phase == 2'h0);
						if (phase == 2'h3)
						begin
							state <= ST_IDLE;
							owned <= 1'b0;
							cmd[`SCS_CMD_STOP] <= 1'b0;
							i2c_st[`SCS_ST_CMDFIN] <= 1'b1;
							fin_set[`SCS_ST_CMDFIN] <= 1'b1;
						end
					end
					ST_BIT:
					begin
						// Data set while SCL low, SCL high for two quarters, sample in the middle
						if (phase == 2'h0)
						begin
							o_scl_oe <= 1'b1;
							o_sda_oe <= !shreg[8];
						end
						if (phase == 2'h1)
							o_scl_oe <= 1'b0;
						if (phase == 2'h2)
							shreg <= {shreg[7:0], sda_pin};
						if (phase == 2'h3)
						begin
							o_scl_oe <= 1'b1;
							bit_n <= bit_n + 4'h1;
							if (bit_n == 4'h8)
							begin
								state <= ST_IDLE;
								o_scl_oe <= 1'b1;
								o_sda_oe <= 1'b0;
								if (cmd[`SCS_CMD_SEND])
								begin
									cmd[`SCS_CMD_SEND] <= 1'b0;
									i2c_st[`SCS_ST_TXFIN] <= 1'b1;
									i2c_st[`SCS_ST_NACK]  <= shreg[0];
									fin_set[`SCS_ST_TXFIN] <= 1'b1;
									fin_set[`SCS_ST_NACK]  <= shreg[0];
								end
								else
								begin
									cmd[`SCS_CMD_RECV] <= 1'b0;
									i2c_st[`SCS_ST_RXFIN] <= 1'b1;
									fin_set[`SCS_ST_RXFIN] <= 1'b1;
									rx_byte <= shreg[8:1];
									rx_push <= 1'b1;
								end
							end
						end
					end
					default: state <= ST_IDLE;
				endcase
			end
			o_scl_out <= 1'b0;
			o_sda_out <= 1'b0;
		end
	end
endmodule // scs_ctrl

// ==== src/scs_defs.vh ====
`ifndef SCS_DEFS_VH
`define SCS_DEFS_VH

// Register indices (byte address = 4 * index)
`define SCS_IDX_DMA_CTRL   16'h4418
`define SCS_IDX_DATA       16'h441e
`define SCS_IDX_SPI_STAT   16'h4420
`define SCS_IDX_I2C_STAT   16'h4422
`define SCS_IDX_I2C_CMD    16'h4426
`define SCS_IDX_I2C_ACK    16'h4428
`define SCS_IDX_MODE       16'h4424
`define SCS_IDX_IRQ_STAT   16'h4440
`define SCS_IDX_IRQ_MASK   16'h4442
`define SCS_ADDR_W         18

// spi_status bits
`define SCS_SPI_TXIDLE     3
`define SCS_SPI_TXSPACE    2
`define SCS_SPI_RXVALID    1
`define SCS_SPI_RXOVR      0

// i2c_command bits
`define SCS_CMD_STOP       3
`define SCS_CMD_START      2
`define SCS_CMD_SEND       1
`define SCS_CMD_RECV       0

// i2c_status bits
`define SCS_ST_CMDFIN      3
`define SCS_ST_RXFIN       2
`define SCS_ST_TXFIN       1
`define SCS_ST_NACK        0

// dma_buffer_control bits
`define SCS_DMA_TXRST      5
`define SCS_DMA_RXRST      4

// Mode field values
`define SCS_MODE_SPI       2'h2
`define SCS_MODE_I2C       2'h3

// Reset values
`define SCS_RST_ACK        1'h0
`define SCS_RST_MODE       2'h0

// Link timing: a quarter bit lasts this value plus one clock ticks; then the buffer service done count
`define SCS_QTR_DEF        16'h0040
`define SCS_DMA_DONE_CYC   8'h10

`endif

// ==== src/scs_fifo.v ====
`timescale 1ns/1ps
`include "scs_defs.vh"

module scs_fifo #(
	parameter W  = 8,
	parameter AW = 2
) (
	input  wire         i_clk_sys,
	input  wire         i_rstn,
	input  wire         i_clr,
	input  wire         i_push,
	input  wire [W-1:0] i_wdata,
	input  wire         i_pop,
	output reg  [W-1:0] o_rdata,
	output wire         o_empty,
	output wire         o_full
);
	reg [W-1:0] mem [0:(1<<AW)-1];
	reg [AW:0]  wp;
	reg [AW:0]  rp;
	wire        wr_ok   = i_push && !o_full;
	wire [AW:0] next_rp = rp + {{AW{1'b0}}, (i_pop && !o_empty)};

	assign o_empty = (wp == rp);
	assign o_full  = (wp[AW] != rp[AW]) && (wp[AW-1:0] == rp[AW-1:0]);

	always @(posedge i_clk_sys)
	begin
		if (i_push && !o_full)
			mem[wp[AW-1:0]] <= i_wdata;
	end

	always @(posedge i_clk_sys or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			wp      <= {(AW+1){1'b0}};
			rp      <= {(AW+1){1'b0}};
			o_rdata <= {W{1'b0}};
		end
		else if (i_clr)
		begin
			wp      <= {(AW+1){1'b0}};
			rp      <= {(AW+1){1'b0}};
			o_rdata <= {W{1'b0}};
		end
		else
		begin
			if (wr_ok)
				wp <= wp + 1'b1;
			rp <= next_rp;
			// Head of queue kept registered; bypass when it is written now
			o_rdata <= (wr_ok && next_rp == wp) ? i_wdata : mem[next_rp[AW-1:0]];
		end
	end
endmodule // scs_fifo

// ==== testbench/scs_asserts.sv ====
`timescale 1ns/1ps
`include "scs_defs.vh"
module scs_asserts (
	input wire logic        i_clk_sys,
	input wire logic        i_rstn,
	input wire logic [19:0] i_awaddr,
	input wire logic        i_awvalid,
	input wire logic        o_awready,
	input wire logic [1:0]  o_bresp,
	input wire logic        o_bvalid,
	input wire logic        i_bready,
	input wire logic [19:0] i_araddr,
	input wire logic        i_arvalid,
	input wire logic        o_arready,
	input wire logic [31:0] o_rdata,
	input wire logic [1:0]  o_rresp,
	input wire logic        o_rvalid,
	input wire logic        i_rready,
	input wire logic        o_scl_out,
	input wire logic        o_sda_out
);
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_rstn);
	reg [17:0] wa;
	reg [17:0] ra;
	// Index of the transfer in flight
	always @(posedge i_clk_sys or negedge i_rstn)
		if (!i_rstn)
		begin
			wa <= 18'h0;
			ra <= 18'h0;
		end
		else
		begin
			if (i_awvalid && o_awready)
				wa <= i_awaddr[19:2];
			if (i_arvalid && o_arready)
				ra <= i_araddr[19:2];
		end
	function automatic logic mapd(input logic [17:0] x);
		mapd = x[17:16] == 2'h0 && (x[15:0] == `SCS_IDX_DMA_CTRL || x[15:0] == `SCS_IDX_DATA
			|| x[15:0] == `SCS_IDX_SPI_STAT || x[15:0] == `SCS_IDX_I2C_STAT || x[15:0] == `SCS_IDX_I2C_CMD
			|| x[15:0] == `SCS_IDX_I2C_ACK || x[15:0] == `SCS_IDX_MODE || x[15:0] == `SCS_IDX_IRQ_STAT
			|| x[15:0] == `SCS_IDX_IRQ_MASK);
	endfunction
	a_bvalid_hold: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp))
		else $error("bvalid dropped early");
	a_rvalid_hold: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("rvalid dropped early");
	a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
		else $error("read answer late");
	a_bresp_map: assert property (o_bvalid |-> o_bresp == (mapd(wa) ? 2'h0 : 2'h2))
		else $error("bad write response");
	a_rresp_map: assert property (o_rvalid |-> o_rresp == (mapd(ra) ? 2'h0 : 2'h2) && (mapd(ra) || o_rdata == 32'h0))
		else $error("bad read response");
	a_flag_upper: assert property (o_rvalid && (ra == {2'h0, `SCS_IDX_SPI_STAT} || ra == {2'h0, `SCS_IDX_I2C_STAT}
		|| ra == {2'h0, `SCS_IDX_I2C_CMD}) |-> o_rdata[31:4] == 28'h0) else $error("upper status bits set");
	a_dma_wo: assert property (o_rvalid && ra == {2'h0, `SCS_IDX_DMA_CTRL} |-> o_rdata[31:4] == 28'h0)
		else $error("dma reset bits readable");
	a_ack_field: assert property (o_rvalid && ra == {2'h0, `SCS_IDX_I2C_ACK} |-> o_rdata[31:1] == 31'h0)
		else $error("ack register upper bits set");
	a_open_drain: assert property (o_scl_out == 1'b0 && o_sda_out == 1'b0)
		else $error("pin driven high");
endmodule // scs_asserts
bind scs_ctrl scs_asserts scs_asserts_inst (.*);

// ==== testbench/scs_i2c_slave.sv ====
`timescale 1ns/1ps
module scs_i2c_slave (
	input  wire logic       i_scl,
	input  wire logic       i_sda,
	input  wire logic       i_rd,
	input  wire logic       i_nack,
	input  wire logic [7:0] i_byte,
	output wire logic       o_sda_oe,
	output logic      [7:0] o_got,
	output logic            o_ack_seen
);
	integer bit_n = 0;
	integer ph = 0;
	initial
	begin
		o_got = 8'h0;
		o_ack_seen = 1'b0;
	end
	// Read data while low phase, ack slot on writes
	assign o_sda_oe = i_rd ? (ph < 8 && !i_byte[7 - ph]) : (ph == 8 && !i_nack);
	// Start or repeated start
	always @(negedge i_sda)
		if (i_scl)
			bit_n = 0;
	always @(posedge i_scl)
	begin
		if (bit_n < 8)
			o_got = {o_got[6:0], i_sda};
		else
			o_ack_seen = !i_sda;
		bit_n = bit_n + 1;
	end
	always @(negedge i_scl)
	begin
		#2;
		if (bit_n >= 9)
			bit_n = 0;
		ph = bit_n;
	end
endmodule // scs_i2c_slave

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`include "scs_defs.vh"
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin err_total++; $display("mismatch %s exp %h got %h", n, e, s); end end
module testbench;
	reg         clk = 0;
	reg         rstn = 0;
	reg  [19:0] awaddr = 0;
	reg  [19:0] araddr = 0;
	reg  [31:0] wdata = 0;
	reg         awvalid = 0;
	reg         wvalid = 0;
	reg         bready = 0;
	reg         arvalid = 0;
	reg         rready = 0;
	reg         s_rd = 0;
	reg         s_nack = 0;
	reg  [7:0]  s_byte = 0;
	wire [31:0] rdata;
	wire [1:0]  bresp;
	wire [1:0]  rresp;
	wire        awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, s_oe, irq, s_ack;
	wire [7:0]  s_got;
	wire        scl = !scl_oe;
	wire        sda = !(sda_oe | s_oe);
	reg  [31:0] d;
	reg  [1:0]  r;
	integer     err_total = 0;
	integer     checks = 0;
	integer     cyc = 0;
	integer     i;
	scs_ctrl #(.QTR_TICKS(16'h0004)) scs_ctrl_inst (.i_clk_sys(clk), .i_rstn(rstn), .i_awaddr(awaddr),
		.i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata), .i_wstrb(4'hf), .i_wvalid(wvalid),
		.o_wready(wready), .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
		.i_rready(rready), .i_scl_in(scl), .o_scl_out(), .o_scl_oe(scl_oe), .i_sda_in(sda), .o_sda_out(),
		.o_sda_oe(sda_oe), .o_irq(irq));
	scs_i2c_slave scs_i2c_slave_inst (.i_scl(scl), .i_sda(sda), .i_rd(s_rd), .i_nack(s_nack),
		.i_byte(s_byte), .o_sda_oe(s_oe), .o_got(s_got), .o_ack_seen(s_ack));
	initial
		forever #4 clk = ~clk;
	always @(posedge clk)
	begin
		cyc = cyc + 1;
		if (cyc == 60000)
		begin
			err_total++;
			conclude;
		end
	end
	task conclude;
		begin
			$display("checks %0d err_total %0d", checks, err_total);
			if (err_total == 0 && checks > 0)
				$display("== PASSED ==");
			else
				$display("== FAILED ==");
			$finish;
		end
	endtask
	task wr(input [15:0] a, input [31:0] v);
		begin
			@(posedge clk);
			awaddr <= {2'h0, a, 2'h0};
			wdata <= v;
			awvalid <= 1'b1;
			wvalid <= 1'b1;
			bready <= 1'b1;
			do
			begin
				@(posedge clk);
				if (awready)
					awvalid <= 1'b0;
				if (wready)
					wvalid <= 1'b0;
			end while (bvalid !== 1'b1);
			bready <= 1'b0;
		end
	endtask
	task rd(input [15:0] a);
		begin
			@(posedge clk);
			araddr <= {2'h0, a, 2'h0};
			arvalid <= 1'b1;
			rready <= 1'b1;
			do
			begin
				@(posedge clk);
				if (arready)
					arvalid <= 1'b0;
			end while (rvalid !== 1'b1);
			d = rdata;
			r = rresp;
			rready <= 1'b0;
		end
	endtask
	// Issue a command, wait for self-clear, check flags
	task run(input [3:0] c, input [3:0] st);
		begin
			wr(`SCS_IDX_I2C_CMD, {28'h0, c});
			d = 32'h1;
			for (i = 0; i < 400 && d[3:0] != 4'h0; i++)
				rd(`SCS_IDX_I2C_CMD);
			`CHK("i2c_command", 32'h0, d)
			rd(`SCS_IDX_I2C_STAT);
			`CHK("i2c_status", {28'h0, st}, d)
		end
	endtask
	task t_reset;
		begin
			rd(`SCS_IDX_I2C_ACK);
			`CHK("i2c_ack", 32'h0, d)
			rd(`SCS_IDX_SPI_STAT);
			`CHK("spi_status", 32'hc, d)
			wr(`SCS_IDX_SPI_STAT, 32'hf);
			rd(`SCS_IDX_SPI_STAT);
			`CHK("spi_status ro", 32'hc, d)
			rd(16'h0100);
			`CHK("unmapped resp", 2'h2, r)
		end
	endtask
	task t_start;
		begin
			wr(`SCS_IDX_MODE, {30'h0, `SCS_MODE_I2C});
			wr(`SCS_IDX_IRQ_MASK, 32'hf);
			run(4'h4, 4'h8);
			`CHK("irq set", 1'b1, irq)
			rd(`SCS_IDX_IRQ_STAT);
			`CHK("irq_status", 32'h8, d)
			repeat (3) @(posedge clk);
			`CHK("irq cleared", 1'b0, irq)
		end
	endtask
	task t_send(input nk, input [7:0] v);
		begin
			s_rd <= 1'b0;
			s_nack <= nk;
			wr(`SCS_IDX_DATA, {24'h1, v});
			run(4'h2, nk ? 4'h3 : 4'h2);
			`CHK("byte on wire", v, s_got)
			rd(`SCS_IDX_SPI_STAT);
			`CHK("tx idle", 1'b1, d[3])
		end
	endtask
	task t_recv(input ak, input [7:0] v);
		begin
			s_rd <= 1'b1;
			s_byte <= v;
			wr(`SCS_IDX_I2C_ACK, {31'h0, ak});
			run(4'h1, 4'h4);
			`CHK("master ack", ak, s_ack)
			rd(`SCS_IDX_SPI_STAT);
			`CHK("rx valid", 1'b1, d[1])
		end
	endtask
	task t_overrun;
		begin
			for (int k = 0; k < 5; k++)
				t_recv(1'b0, 8'h10 + k[7:0]);
			rd(`SCS_IDX_SPI_STAT);
			`CHK("overrun set", 1'b1, d[0])
			rd(`SCS_IDX_DATA);
			`CHK("oldest byte", 32'h10, d)
			rd(`SCS_IDX_SPI_STAT);
			`CHK("overrun clear", 1'b0, d[0])
		end
	endtask
	task t_dma;
		begin
			wr(`SCS_IDX_DMA_CTRL, 32'h1);
			wr(`SCS_IDX_DMA_CTRL, 32'h0);
			rd(`SCS_IDX_DMA_CTRL);
			`CHK("load pending", 32'h1, d)
			repeat (24) @(posedge clk);
			rd(`SCS_IDX_DMA_CTRL);
			`CHK("load done", 32'h0, d)
			wr(`SCS_IDX_DMA_CTRL, 32'h3f);
			rd(`SCS_IDX_DMA_CTRL);
			`CHK("reset clears", 32'h0, d)
			wr(`SCS_IDX_DMA_CTRL, 32'hf);
			rd(`SCS_IDX_DMA_CTRL);
			`CHK("loads set", 32'hf, d)
			wr(`SCS_IDX_DMA_CTRL, 32'h30);
			rd(`SCS_IDX_DMA_CTRL);
			`CHK("reset bits", 32'h0, d)
		end
	endtask
	initial
	begin
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		repeat (3) @(posedge clk);
		t_reset;
		t_start;
		t_send(1'b0, 8'ha5);
		t_send(1'b1, 8'h5a);
		run(4'h4, 4'h8);
		t_recv(1'b1, 8'h3c);
		rd(`SCS_IDX_DATA);
		`CHK("rx byte", 32'h3c, d)
		t_recv(1'b0, 8'hc3);
		rd(`SCS_IDX_DATA);
		`CHK("rx byte 2", 32'hc3, d)
		t_overrun;
		s_rd <= 1'b0;
		run(4'h8, 4'h8);
		t_dma;
		conclude;
	end
endmodule // testbench
